// >>> pkg/fbi_pkg.sv
package fbi_pkg;
    localparam int         ADDR_W     = 20;
    localparam int         DATA_W     = 16;
    localparam logic [7:0] CMD_READ   = 8'hff;
    localparam logic [7:0] CMD_CFG    = 8'h90;
    localparam logic [7:0] CMD_QUERY  = 8'h98;
    localparam logic [7:0] CMD_STATUS = 8'h70;
    localparam logic [7:0] CMD_CLRST  = 8'h50;
    localparam logic [7:0] CMD_ERASE  = 8'h20;
    localparam logic [7:0] CMD_WRITE  = 8'h40;
    localparam logic [7:0] CMD_WRITE2 = 8'h10;
    localparam logic [7:0] CMD_SUSP   = 8'hb0;
    localparam logic [7:0] CMD_CONF   = 8'hd0;
    localparam logic [7:0] CMD_LOCK   = 8'h60;
    localparam logic [7:0] LOCK_SET   = 8'h01;
    localparam logic [7:0] LOCK_CLR   = 8'hd0;
    localparam logic [7:0] ST_READY   = 8'h80;
    localparam int         ST_RDY_BIT = 7;
    // pulse widths in ns at a 40 MHz clock
    localparam int         CLK_NS     = 25;
    localparam int         T_PULSE_NS = 70;
    localparam int         T_SETUP_NS = 30;
    localparam int         T_RST_NS   = 100;
    localparam int         T_WAKE_NS  = 150;
    localparam int PULSE_CYC = (T_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int SETUP_CYC = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int RST_CYC   = (T_RST_NS + CLK_NS - 1) / CLK_NS;
    localparam int WAKE_CYC  = (T_WAKE_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W     = 4;
    // sector map
    localparam logic [19:0] SMALL_TOP_BASE = 20'hf8000;
    localparam logic [19:0] SMALL_BOT_END  = 20'h07fff;
    localparam int          SMALL_SHIFT    = 12;
    localparam int          MAIN_SHIFT     = 15;
    localparam int          SECT_W         = 6;
    typedef enum logic [2:0] {
        FBI_OP_READ, FBI_OP_CMD, FBI_OP_ERASE, FBI_OP_WRITE,
        FBI_OP_LOCK, FBI_OP_UNLOCK, FBI_OP_RESET
    } fbi_op_t;
endpackage

// >>> pkg/fbi_seq_if.sv
`timescale 1ns/1ps
interface fbi_seq_if;
    logic                          start;
    logic                          is_write;
    logic [fbi_pkg::ADDR_W-1:0]   addr;
    logic [fbi_pkg::DATA_W-1:0]   wdata;
    logic                          done;
    logic [fbi_pkg::DATA_W-1:0]   rdata;
    modport ctl (output start, is_write, addr, wdata, input done, rdata);
    modport cyc (input start, is_write, addr, wdata, output done, rdata);
endinterface

// >>> hdl/fbi_bus_cycle.sv
`timescale 1ns/1ps
module fbi_bus_cycle
(
    input  wire logic                        mclk,
    input  wire logic                        arst_n,
    fbi_seq_if.cyc                           seq,
    output logic                             flash_select_n,
    output logic                             flash_out_enable_n,
    output logic                             flash_write_strobe_n,
    output logic [fbi_pkg::ADDR_W-1:0]       addr_o,
    output logic [fbi_pkg::DATA_W-1:0]       data_pins_o,
    output logic                             data_pins_oe,
    input  wire logic [fbi_pkg::DATA_W-1:0]  data_pins_i
);
    typedef enum logic [1:0] {FBI_C_IDLE, FBI_C_SETUP, FBI_C_PULSE,
                              FBI_C_HOLD} fbi_cst_t;
    typedef struct packed {
        fbi_cst_t                       st;
        logic [fbi_pkg::CNT_W-1:0]      cnt;
        logic                           wr;
        logic                           sel_n;
        logic                           oe_n;
        logic                           we_n;
        logic [fbi_pkg::ADDR_W-1:0]     addr;
        logic [fbi_pkg::DATA_W-1:0]     dout;
        logic                           doe;
        logic [fbi_pkg::DATA_W-1:0]     rdata;
        logic                           done;
    } fbi_cyc_t;
    localparam logic [fbi_pkg::CNT_W-1:0] SETUP_C =
        fbi_pkg::CNT_W'(fbi_pkg::SETUP_CYC);
    localparam logic [fbi_pkg::CNT_W-1:0] PULSE_C =
        fbi_pkg::CNT_W'(fbi_pkg::PULSE_CYC);
    fbi_cyc_t s_q, s_d;

    always_comb
    begin
        s_d      = s_q;
        s_d.done = 1'b0;
        unique case (s_q.st)
            FBI_C_IDLE:
            begin
                if (seq.start)
                begin
                    // address set up before select falls
                    s_d.addr  = seq.addr;
                    s_d.wr    = seq.is_write;
                    s_d.dout  = seq.wdata;
                    s_d.cnt   = SETUP_C;
                    s_d.st    = FBI_C_SETUP;
                end
            end
            FBI_C_SETUP:
            begin
                // select falls with address stable
                s_d.sel_n = 1'b0;
                s_d.doe   = s_q.wr;
                if (s_q.cnt == '0)
                begin
                    s_d.we_n = !s_q.wr;
                    s_d.oe_n = s_q.wr;
                    s_d.cnt  = PULSE_C;
                    s_d.st   = FBI_C_PULSE;
                end
                else
                    s_d.cnt = s_q.cnt - 1'b1;
            end
            FBI_C_PULSE:
            begin
                if (s_q.cnt == '0)
                begin
                    // data latched by the device on strobe rise
                    s_d.we_n  = 1'b1;
                    s_d.oe_n  = 1'b1;
                    s_d.rdata = data_pins_i;
                    s_d.st    = FBI_C_HOLD;
                end
                else
                    s_d.cnt = s_q.cnt - 1'b1;
            end
            FBI_C_HOLD:
            begin
                // data held one cycle past strobe rise
                s_d.sel_n = 1'b1;
                s_d.doe   = 1'b0;
                s_d.done  = 1'b1;
                s_d.st    = FBI_C_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_q       <= '0;
            s_q.st    <= FBI_C_IDLE;
            s_q.sel_n <= 1'b1;
            s_q.oe_n  <= 1'b1;
            s_q.we_n  <= 1'b1;
        end
        else
            s_q <= s_d;
    end

    assign flash_select_n       = s_q.sel_n;
    assign flash_out_enable_n   = s_q.oe_n;
    assign flash_write_strobe_n = s_q.we_n;
    assign addr_o               = s_q.addr;
    assign data_pins_o          = s_q.dout;
    assign data_pins_oe         = s_q.doe;
    assign seq.done             = s_q.done;
    assign seq.rdata            = s_q.rdata;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    property p_no_contention;
        @(posedge mclk) disable iff (!arst_n)
        !(data_pins_oe && !flash_out_enable_n);
    endproperty
    a_no_contention: assert property (p_no_contention)
        else $error("host drives data while read enabled");

    property p_read_strobe_high;
        @(posedge mclk) disable iff (!arst_n)
        !flash_out_enable_n |-> flash_write_strobe_n;
    endproperty
    a_read_strobe_high: assert property (p_read_strobe_high)
        else $error("write strobe low during read");

    property p_strobe_in_select;
        @(posedge mclk) disable iff (!arst_n)
        !flash_write_strobe_n |-> !flash_select_n && data_pins_oe;
    endproperty
    a_strobe_in_select: assert property (p_strobe_in_select)
        else $error("strobe low outside select");

    property p_addr_stable;
        @(posedge mclk) disable iff (!arst_n)
        !flash_select_n && !$past(flash_select_n) |-> $stable(addr_o);
    endproperty
    a_addr_stable: assert property (p_addr_stable)
        else $error("address moved during select");
endmodule // fbi_bus_cycle

// >>> hdl/fbi_host.sv
`timescale 1ns/1ps
module fbi_host
(
    input  wire logic                        mclk,
    input  wire logic                        arst_n,
    input  wire logic                        req_valid,
    input  wire fbi_pkg::fbi_op_t            req_op,
    input  wire logic [fbi_pkg::ADDR_W-1:0]  req_addr,
    input  wire logic [fbi_pkg::DATA_W-1:0]  req_data,
    input  wire logic                        top_boot,
    input  wire logic                        prog_supply_ok,
    input  wire logic                        flash_supply_ok,
    output logic                             req_ready,
    output logic                             rsp_valid,
    output logic [fbi_pkg::DATA_W-1:0]       rsp_data,
    output logic                             rsp_refused,
    output logic [fbi_pkg::SECT_W-1:0]       rsp_sector,
    output logic                             flash_reset_n,
    output logic                             flash_select_n,
    output logic                             flash_out_enable_n,
    output logic                             flash_write_strobe_n,
    output logic [fbi_pkg::ADDR_W-1:0]       flash_addr,
    output logic [fbi_pkg::DATA_W-1:0]       data_pins_o,
    output logic                             data_pins_oe,
    input  wire logic [fbi_pkg::DATA_W-1:0]  data_pins_i
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {FBI_H_RST, FBI_H_WAKE, FBI_H_IDLE,
                              FBI_H_CYC1, FBI_H_CYC2, FBI_H_DONE}
        fbi_hst_t;
    typedef struct packed {
        fbi_hst_t                       st;
        logic [fbi_pkg::CNT_W-1:0]      cnt;
        fbi_pkg::fbi_op_t               op;
        logic [fbi_pkg::ADDR_W-1:0]     addr;
        logic [fbi_pkg::DATA_W-1:0]     data;
        logic                           start;
        logic                           ready;
        logic                           rvalid;
        logic [fbi_pkg::DATA_W-1:0]     rdata;
        logic                           refused;
        logic [fbi_pkg::SECT_W-1:0]     sector;
        logic                           rst_n;
    } fbi_host_t;
    localparam logic [fbi_pkg::CNT_W-1:0] RST_C =
        fbi_pkg::CNT_W'(fbi_pkg::RST_CYC);
    localparam logic [fbi_pkg::CNT_W-1:0] WAKE_C =
        fbi_pkg::CNT_W'(fbi_pkg::WAKE_CYC);
    localparam logic [fbi_pkg::SECT_W-1:0] SMALL_N = 6'h08;
    fbi_host_t h_q, h_d;
    fbi_seq_if seq ();

    // ---------------------------------------------------------------
    // sector decode, small sectors numbered 0..7 from the boot end
    // ---------------------------------------------------------------
    function automatic logic [fbi_pkg::SECT_W-1:0] sector_of(
        input logic [fbi_pkg::ADDR_W-1:0] a, input logic top);
        logic [fbi_pkg::ADDR_W-1:0] inv;
        inv = ~a;
        if (top)
        begin
            if (a >= fbi_pkg::SMALL_TOP_BASE)
                return fbi_pkg::SECT_W'(inv >> fbi_pkg::SMALL_SHIFT);
            return SMALL_N - 6'h01 +
                fbi_pkg::SECT_W'(inv >> fbi_pkg::MAIN_SHIFT);
        end
        if (a <= fbi_pkg::SMALL_BOT_END)
            return fbi_pkg::SECT_W'(a >> fbi_pkg::SMALL_SHIFT);
        return SMALL_N - 6'h01 +
            fbi_pkg::SECT_W'(a >> fbi_pkg::MAIN_SHIFT);
    endfunction

    function automatic logic [7:0] first_code(input fbi_pkg::fbi_op_t o);
        unique case (o)
            fbi_pkg::FBI_OP_ERASE:  return fbi_pkg::CMD_ERASE;
            fbi_pkg::FBI_OP_WRITE:  return fbi_pkg::CMD_WRITE;
            fbi_pkg::FBI_OP_LOCK,
            fbi_pkg::FBI_OP_UNLOCK: return fbi_pkg::CMD_LOCK;
            default:                return fbi_pkg::CMD_READ;
        endcase
    endfunction

    always_comb
    begin
        logic pair_op;
        logic alter_ok;
        pair_op  = 1'b0;
        alter_ok = prog_supply_ok && flash_supply_ok;
        h_d        = h_q;
        h_d.start  = 1'b0;
        h_d.rvalid = 1'b0;
        unique case (h_q.st)
            FBI_H_RST:
            begin
                h_d.rst_n = 1'b0;
                if (h_q.cnt == '0)
                begin
                    h_d.rst_n = 1'b1;
                    h_d.cnt   = WAKE_C;
                    h_d.st    = FBI_H_WAKE;
                end
                else
                    h_d.cnt = h_q.cnt - 1'b1;
            end
            FBI_H_WAKE:
            begin
                // device is in read-array once awake
                if (h_q.cnt == '0)
                begin
                    h_d.ready = 1'b1;
                    h_d.st    = FBI_H_IDLE;
                end
                else
                    h_d.cnt = h_q.cnt - 1'b1;
            end
            FBI_H_IDLE:
            begin
                if (req_valid)
                begin
                    pair_op = req_op inside {fbi_pkg::FBI_OP_ERASE,
                        fbi_pkg::FBI_OP_WRITE, fbi_pkg::FBI_OP_LOCK,
                        fbi_pkg::FBI_OP_UNLOCK};
                    h_d.ready   = 1'b0;
                    h_d.op      = req_op;
                    h_d.addr    = req_addr;
                    h_d.data    = req_data;
                    h_d.refused = 1'b0;
                    h_d.sector  = sector_of(req_addr, top_boot);
                    if (req_op == fbi_pkg::FBI_OP_RESET)
                    begin
                        h_d.cnt = RST_C;
                        h_d.st  = FBI_H_RST;
                    end
                    else if (pair_op && !alter_ok)
                    begin
                        // no alteration under lockout
                        h_d.refused = 1'b1;
                        h_d.st      = FBI_H_DONE;
                    end
                    else
                    begin
                        // reads need no supply
                        h_d.start = 1'b1;
                        h_d.st    = pair_op ? FBI_H_CYC1 : FBI_H_CYC2;
                    end
                end
            end
            FBI_H_CYC1:
            begin
                // setup half of the pair, then confirm
                if (seq.done)
                begin
                    h_d.start = 1'b1;
                    h_d.st    = FBI_H_CYC2;
                end
            end
            FBI_H_CYC2:
            begin
                if (seq.done)
                begin
                    h_d.rdata = seq.rdata;
                    h_d.st    = FBI_H_DONE;
                end
            end
            FBI_H_DONE:
            begin
                // device completes the operation alone
                h_d.rvalid = 1'b1;
                h_d.ready  = 1'b1;
                h_d.st     = FBI_H_IDLE;
            end
            default:
                h_d.st = FBI_H_RST;
        endcase
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            // pulse the device reset on our own reset
            h_q     <= '0;
            h_q.st  <= FBI_H_RST;
            h_q.cnt <= RST_C;
        end
        else
            h_q <= h_d;
    end

    // ---------------------------------------------------------------
    // bus cycle drive
    // ---------------------------------------------------------------
    always_comb
    begin
        seq.start    = h_q.start;
        seq.addr     = h_q.addr;
        seq.is_write = h_q.op != fbi_pkg::FBI_OP_READ &&
                       h_q.op != fbi_pkg::FBI_OP_CMD;
        seq.wdata    = h_q.data;
        if (h_q.st == FBI_H_CYC1)
            seq.wdata = {8'h00, first_code(h_q.op)};
        else if (h_q.op == fbi_pkg::FBI_OP_ERASE)
            seq.wdata = {8'h00, fbi_pkg::CMD_CONF};
        else if (h_q.op == fbi_pkg::FBI_OP_LOCK)
            seq.wdata = {8'h00, fbi_pkg::LOCK_SET};
        else if (h_q.op == fbi_pkg::FBI_OP_UNLOCK)
            seq.wdata = {8'h00, fbi_pkg::LOCK_CLR};
        if (h_q.op == fbi_pkg::FBI_OP_CMD)
            seq.is_write = 1'b1;
    end

    fbi_bus_cycle u_cyc
    (
        .mclk                 (mclk),
        .arst_n               (arst_n),
        .seq                  (seq),
        .flash_select_n       (flash_select_n),
        .flash_out_enable_n   (flash_out_enable_n),
        .flash_write_strobe_n (flash_write_strobe_n),
        .addr_o               (flash_addr),
        .data_pins_o          (data_pins_o),
        .data_pins_oe         (data_pins_oe),
        .data_pins_i          (data_pins_i)
    );

    assign req_ready     = h_q.ready;
    assign rsp_valid     = h_q.rvalid;
    assign rsp_data      = h_q.rdata;
    assign rsp_refused   = h_q.refused;
    assign rsp_sector    = h_q.sector;
    assign flash_reset_n = h_q.rst_n;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    sequence s_first_cycle;
        h_q.st == FBI_H_CYC1 && seq.done;
    endsequence
    sequence s_second_start;
        ##1 seq.start && h_q.st == FBI_H_CYC2;
    endsequence
    property p_pair;
        @(posedge mclk) disable iff (!arst_n)
        s_first_cycle |-> s_second_start;
    endproperty
    a_pair: assert property (p_pair)
        else $error("confirm cycle did not follow setup");

    property p_lockout;
        @(posedge mclk) disable iff (!arst_n)
        h_q.st == FBI_H_IDLE && req_valid && !prog_supply_ok &&
        req_op == fbi_pkg::FBI_OP_WRITE |=> rsp_refused ##1 rsp_valid;
    endproperty
    a_lockout: assert property (p_lockout)
        else $error("write issued under supply lockout");

    property p_reset_width;
        @(posedge mclk) disable iff (!arst_n)
        $fell(flash_reset_n) |-> !flash_reset_n [*4];
    endproperty
    a_reset_width: assert property (p_reset_width)
        else $error("device reset pulse too short");

    property p_read_idle_reset;
        @(posedge mclk) disable iff (!arst_n)
        !flash_out_enable_n |-> flash_reset_n;
    endproperty
    a_read_idle_reset: assert property (p_read_idle_reset)
        else $error("read while device reset low");

    property p_read_first;
        @(posedge mclk) disable iff (!arst_n)
        $rose(h_q.ready) && h_q.st == FBI_H_IDLE |-> flash_select_n;
    endproperty
    a_read_first: assert property (p_read_first)
        else $error("bus busy at wake-up");

    property p_top_main;
        @(posedge mclk) disable iff (!arst_n)
        h_q.st == FBI_H_IDLE && req_valid && top_boot &&
        req_addr == 20'h00000 |=> rsp_sector == 6'h26;
    endproperty
    a_top_main: assert property (p_top_main)
        else $error("bottom main sector mis-decoded");

    property p_bot_main;
        @(posedge mclk) disable iff (!arst_n)
        h_q.st == FBI_H_IDLE && req_valid && !top_boot &&
        req_addr == 20'h08000 |=> rsp_sector == 6'h08;
    endproperty
    a_bot_main: assert property (p_bot_main)
        else $error("first main sector mis-decoded");
endmodule // fbi_host

// >>> verification/fbi_flash_model.sv
`timescale 1ns/1ps
// ------------------
// flash device model
// ------------------
module fbi_flash_model
#(
    parameter logic [15:0] CFG_CODE = 16'h00c3 // arbitrary value
)
(
    input  wire logic        reset_n,
    input  wire logic        select_n,
    input  wire logic        out_enable_n,
    input  wire logic        write_strobe_n,
    input  wire logic [19:0] addr,
    input  wire logic [15:0] din,
    input  wire logic        prog_ok,
    input  wire logic        supply_ok,
    output logic      [15:0] dq,
    output logic             dq_oe
);
    // small array, so addresses alias every 256 words
    logic [15:0] mem [0:255];
    logic [1:0]  mode = 2'h0;
    logic [7:0]  stat = 8'h80;
    logic [7:0]  pend = 8'h00;
    logic [19:0] lat_a;
    logic [19:0] last_addr;
    logic [15:0] last_pair;
    logic [15:0] rd;
    logic [15:0] hold = 16'h0000;
    int          n_we = 0;
    // work ends at once, so suspend only marks the state
    logic        susp = 1'b0;

    initial foreach (mem[i]) mem[i] = 16'hffff;
    always @(negedge reset_n)
    begin
        mode = 2'h0;
        stat = 8'h80;
        pend = 8'h00;
        susp = 1'b0;
    end
    always @(negedge select_n) lat_a = addr;
    // work finishes at once: status stays ready, no polling needed
    always @(posedge write_strobe_n)
    begin
        n_we++;
        if (reset_n && !select_n && pend != 8'h00)
        begin
            last_pair = {pend, din[7:0]};
            last_addr = lat_a;
            if (prog_ok && supply_ok && pend != 8'h20 && pend != 8'h60)
                mem[lat_a[7:0]] = din;
            pend = 8'h00;
        end
        else if (reset_n && !select_n)
        begin
            case (din[7:0])
                8'hff: mode = 2'h0;
                8'h70: mode = 2'h1;
                8'h90: mode = 2'h2;
                8'h20, 8'h40, 8'h10, 8'h60: pend = din[7:0];
                8'hb0: susp = 1'b1;
                8'hd0: susp = 1'b0;
                default: ;
            endcase
        end
    end
    assign dq_oe = reset_n && !select_n && !out_enable_n;
    always @*
    begin
        rd = mem[addr[7:0]];
        if (mode == 2'h1) rd = {8'h00, stat};
        if (mode == 2'h2) rd = CFG_CODE;
    end
    // released bus shows the inverse, never the last word
    always @* if (dq_oe) hold = rd;
    assign dq = dq_oe ? rd : ~hold;
endmodule // fbi_flash_model

// >>> verification/flash_bus_interface_sector_map_tb.sv
`timescale 1ns/1ps
module flash_bus_interface_sector_map_tb;
    logic mclk = 0, arst_n = 0, req_valid = 0, top_boot = 1, p_ok = 1, f_ok = 1;
    fbi_pkg::fbi_op_t req_op = fbi_pkg::FBI_OP_READ;
    logic [19:0] req_addr = 20'h00000, f_addr;
    logic [15:0] req_data = 16'h0000, rsp_data, dp_o, dq, dbus;
    logic [5:0]  rsp_sector;
    logic        req_ready, rsp_valid, rsp_refused, f_rst_n, sel_n, oe_n, we_n;
    logic        dp_oe, dq_oe;
    int          n_fail = 0, n_checks = 0, n;
    logic [26:0] tbl [0:14] = '{{1'b1,20'hff000,6'h00}, {1'b1,20'hfe000,6'h01},
        {1'b1,20'hf8fff,6'h07}, {1'b1,20'hf7fff,6'h08}, {1'b1,20'he8000,6'h09},
        {1'b1,20'h07fff,6'h26}, {1'b1,20'h00000,6'h26}, {1'b0,20'h00000,6'h00},
        {1'b0,20'h01000,6'h01}, {1'b0,20'h07fff,6'h07}, {1'b0,20'h08000,6'h08},
        {1'b0,20'h10000,6'h09}, {1'b0,20'hf8000,6'h26}, {1'b0,20'hfffff,6'h26},
        {1'b1,20'hf0000,6'h08}};

    always #12.5 mclk = ~mclk;
    assign dbus = dp_oe ? dp_o : dq;
    fbi_host i_dut (.mclk(mclk), .arst_n(arst_n), .req_valid(req_valid),
        .req_op(req_op), .req_addr(req_addr), .req_data(req_data),
        .top_boot(top_boot), .prog_supply_ok(p_ok), .flash_supply_ok(f_ok),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .rsp_refused(rsp_refused), .rsp_sector(rsp_sector),
        .flash_reset_n(f_rst_n), .flash_select_n(sel_n),
        .flash_out_enable_n(oe_n), .flash_write_strobe_n(we_n),
        .flash_addr(f_addr), .data_pins_o(dp_o), .data_pins_oe(dp_oe),
        .data_pins_i(dbus));
    fbi_flash_model i_dev (.reset_n(f_rst_n), .select_n(sel_n),
        .out_enable_n(oe_n), .write_strobe_n(we_n), .addr(f_addr),
        .din(dbus), .prog_ok(p_ok), .supply_ok(f_ok), .dq(dq), .dq_oe(dq_oe));

    // -------
    // helpers
    // -------
    task automatic check(input logic [19:0] got, input logic [19:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // called at a falling edge; waits for ready, then for the answer unless the op is a reset
    task automatic req(input fbi_pkg::fbi_op_t op, input logic [19:0] a,
                       input logic [15:0] d);
        n = 0;
        while (req_ready !== 1'b1 && n < 200)
        begin
            @(negedge mclk);
            n++;
        end
        check({19'h0, req_ready}, 20'h1);
        req_valid = 1;
        req_op = op;
        req_addr = a;
        req_data = d;
        @(negedge mclk);
        req_valid = 0;
        n = 0;
        while (op != fbi_pkg::FBI_OP_RESET && rsp_valid !== 1'b1 && n < 100)
        begin
            @(negedge mclk);
            n++;
        end
        if (op != fbi_pkg::FBI_OP_RESET) check({19'h0, rsp_valid}, 20'h1);
    endtask
    // -------
    // tests
    // -------
    task automatic t_write_read;
        req(fbi_pkg::FBI_OP_READ, 20'h00123, 16'h0000);
        check(rsp_data, 20'h0ffff);
        req(fbi_pkg::FBI_OP_WRITE, 20'h00123, 16'ha5c3);
        check(i_dev.last_pair[15:8], fbi_pkg::CMD_WRITE);
        check(i_dev.last_addr, 20'h00123);
        req(fbi_pkg::FBI_OP_READ, 20'h00123, 16'h0000);
        check(rsp_data, 20'h0a5c3);
        $display("test write_read done");
    endtask
    task automatic t_modes;
        req(fbi_pkg::FBI_OP_CMD, 20'h00000, 16'h0070);
        req(fbi_pkg::FBI_OP_READ, 20'h00123, 16'h0000);
        check(rsp_data, 20'h00080);
        req(fbi_pkg::FBI_OP_CMD, 20'h00000, 16'h0090);
        req(fbi_pkg::FBI_OP_READ, 20'h00000, 16'h0000);
        check(rsp_data, {4'h0, i_dev.CFG_CODE});
        req(fbi_pkg::FBI_OP_RESET, 20'h00000, 16'h0000);
        req(fbi_pkg::FBI_OP_READ, 20'h00123, 16'h0000);
        check(rsp_data, 20'h0a5c3);
        $display("test modes done");
    endtask
    task automatic t_suspend;
        req(fbi_pkg::FBI_OP_CMD, 20'h00000, {8'h00, fbi_pkg::CMD_SUSP});
        check({19'h0, i_dev.susp}, 20'h1);
        req(fbi_pkg::FBI_OP_READ, 20'h00123, 16'h0000);
        check(rsp_data, 20'h0a5c3);
        req(fbi_pkg::FBI_OP_WRITE, 20'h08010, 16'h5aa5);
        req(fbi_pkg::FBI_OP_READ, 20'h08010, 16'h0000);
        check(rsp_data, 20'h05aa5);
        req(fbi_pkg::FBI_OP_CMD, 20'h00000, {8'h00, fbi_pkg::CMD_CONF});
        check({19'h0, i_dev.susp}, 20'h0);
        $display("test suspend done");
    endtask
    task automatic t_sectors;
        logic [15:0] pr [0:2];
        fbi_pkg::fbi_op_t ops [0:2];
        pr = '{{fbi_pkg::CMD_ERASE, fbi_pkg::CMD_CONF},
               {fbi_pkg::CMD_LOCK, fbi_pkg::LOCK_SET},
               {fbi_pkg::CMD_LOCK, fbi_pkg::LOCK_CLR}};
        ops = '{fbi_pkg::FBI_OP_ERASE, fbi_pkg::FBI_OP_LOCK,
                fbi_pkg::FBI_OP_UNLOCK};
        for (int i = 0; i < 15; i++)
        begin
            top_boot = tbl[i][26];
            req(ops[i % 3], tbl[i][25:6], 16'h0000);
            check(rsp_sector, tbl[i][5:0]);
            check(i_dev.last_pair, pr[i % 3]);
            check(i_dev.last_addr, tbl[i][25:6]);
            check(rsp_refused, 1'b0);
        end
        $display("test sectors done");
    endtask
    task automatic t_refuse;
        int w;
        p_ok = 0;
        w = i_dev.n_we;
        req(fbi_pkg::FBI_OP_WRITE, 20'h00040, 16'h1234);
        check(rsp_refused, 1'b1);
        check(20'(i_dev.n_we - w), 20'h0);
        req(fbi_pkg::FBI_OP_READ, 20'h00123, 16'h0000);
        check(rsp_data, 20'h0a5c3);
        p_ok = 1;
        f_ok = 0;
        req(fbi_pkg::FBI_OP_ERASE, 20'h08000, 16'h0000);
        check(rsp_refused, 1'b1);
        f_ok = 1;
        $display("test refuse done");
    endtask

    task automatic wrap_up;
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        #400000;
        n_fail++;
        wrap_up();
    end
    initial
    begin
        repeat (4) @(negedge mclk);
        arst_n = 1;
        t_write_read();
        t_modes();
        t_suspend();
        t_sectors();
        t_refuse();
        wrap_up();
    end
endmodule // flash_bus_interface_sector_map_tb
